/* File: hdl/ssp_pkg.sv */
package ssp_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] SSP_ADR_CTRL = 8'h00;
    localparam logic [7:0] SSP_ADR_BUF = 8'h04;
    localparam logic [7:0] SSP_ADR_STATE = 8'h08;
    localparam logic [7:0] SSP_ADR_PINS = 8'h0C;

    // Reset values
    localparam logic [7:0] SSP_CTRL_RST = 8'h00;
    localparam logic [7:0] SSP_BUF_RST = 8'h00;
    localparam logic [7:0] SSP_PINS_RST = 8'h03;

    // Control register fields
    localparam int SSP_CTL_WRITE_COLLISION_FLAG = 7;
    localparam int SSP_CTL_OV = 6;
    localparam int SSP_CTL_EN = 5;
    localparam int SSP_CTL_CKP = 4;
    localparam int SSP_CTL_MODE_LSB = 0;
    localparam int SSP_MODE_W = 4;

    // Port mode codes
    localparam logic [3:0] SSP_MODE_MDIV4 = 4'h0;
    localparam logic [3:0] SSP_MODE_MDIV16 = 4'h1;
    localparam logic [3:0] SSP_MODE_MDIV64 = 4'h2;
    localparam logic [3:0] SSP_MODE_MTMR = 4'h3;
    localparam logic [3:0] SSP_MODE_SLV_SEL = 4'h4;
    localparam logic [3:0] SSP_MODE_SLV_FREE = 4'h5;

    // State register fields
    localparam int SSP_ST_BF = 0;
    localparam int SSP_ST_PIF = 1;
    localparam int SSP_ST_BUSY = 2;
    localparam int SSP_ST_SCK = 3;
    localparam int SSP_ST_SDI = 4;
    localparam int SSP_ST_SEL = 5;

    // Pin control register fields
    localparam int SSP_PIN_SCK_IN = 0;
    localparam int SSP_PIN_SDO_IN = 1;
    localparam int SSP_PIN_SCK_VAL = 4;
    localparam int SSP_PIN_SDO_VAL = 5;

    // Half bit periods in system clocks for the divided rates
    localparam int SSP_HALF_DIV4 = 2;
    localparam int SSP_HALF_DIV16 = 8;
    localparam int SSP_HALF_DIV64 = 32;

    localparam int SSP_FRAME_BITS = 8;

    typedef enum logic [1:0] {
        SSP_PH_IDLE = 2'b00,
        SSP_PH_LEAD = 2'b01,
        SSP_PH_TRAIL = 2'b11
    } ssp_phase_type;

endpackage

/* File: hdl/ssp_bitclk.sv */
`timescale 1ns/10ps
module ssp_bitclk #(
    parameter int CNT_W = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] rate_i,
    input wire logic period_timer_two_tick_i,
    output logic tick_o
);

    if ((1 << CNT_W) < ssp_pkg::SSP_HALF_DIV64) begin : g_chk
        $error("ssp_bitclk: CNT_W too small for the slowest rate");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit;
    logic use_tmr;
    logic at_limit;

    assign limit = (rate_i == 2'h0) ? CNT_W'(ssp_pkg::SSP_HALF_DIV4 - 1) :
                   (rate_i == 2'h1) ? CNT_W'(ssp_pkg::SSP_HALF_DIV16 - 1) :
                   CNT_W'(ssp_pkg::SSP_HALF_DIV64 - 1);
    assign use_tmr = (rate_i == 2'h3);
    assign at_limit = (cnt_r == limit);

    // One tick per half bit; timer output toggles the bit clock, so it halves
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else if (use_tmr) begin
            cnt_r <= '0;
            tick_o <= period_timer_two_tick_i;
        end else if (at_limit) begin
            cnt_r <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
            tick_o <= 1'b0;
        end
    end

endmodule

/* File: hdl/ssp_spi.sv */
`timescale 1ns/10ps
module ssp_spi #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic sel_n_i,
    input wire logic period_timer_two_tick_i,
    input wire logic sleep_i,
    output logic wake_o
);

    if (ADR_W < 8) begin : g_chk
        $error("ssp_spi: ADR_W must be at least 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] ctrl_r;
    logic [7:0] buf_r;
    logic [7:0] pins_r;
    logic [7:0] shreg_r;
    logic [7:0] shreg_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    ssp_pkg::ssp_phase_type phase_r;
    ssp_pkg::ssp_phase_type phase_nxt;
    logic sck_r;
    logic sck_nxt;
    logic sdo_r;
    logic sdo_nxt;
    logic slv_act_r;
    logic slv_act_nxt;
    logic [1:0] samp_r;
    logic done;
    logic bf_r;
    logic pif_r;
    logic sck_meta_r;
    logic sck_sync_r;
    logic sck_prev_r;
    logic sdi_meta_r;
    logic sdi_sync_r;
    logic sel_meta_r;
    logic sel_sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    wire en = ctrl_r[ssp_pkg::SSP_CTL_EN];
    wire clock_polarity_bit = ctrl_r[ssp_pkg::SSP_CTL_CKP];
    wire [3:0] mode = ctrl_r[ssp_pkg::SSP_CTL_MODE_LSB +: ssp_pkg::SSP_MODE_W];
    wire is_master = en && (mode <= ssp_pkg::SSP_MODE_MTMR);
    wire is_slave = en && (mode == ssp_pkg::SSP_MODE_SLV_SEL ||
                           mode == ssp_pkg::SSP_MODE_SLV_FREE);
    wire sel_gated = (mode == ssp_pkg::SSP_MODE_SLV_SEL);
    wire slave_on = is_slave && (!sel_gated || !sel_sync_r);
    wire sck_is_in = pins_r[ssp_pkg::SSP_PIN_SCK_IN];
    wire sdo_is_in = pins_r[ssp_pkg::SSP_PIN_SDO_IN];

    wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = wb_hit && wb_we_i && wb_sel_i[0];
    wire rd = wb_hit && !wb_we_i;
    wire [7:0] adr = wb_adr_i[7:0];
    wire adr_hi_zero = (wb_adr_i >> 8) == '0;
    wire hit_ctrl = adr_hi_zero && adr == ssp_pkg::SSP_ADR_CTRL;
    wire hit_buf = adr_hi_zero && adr == ssp_pkg::SSP_ADR_BUF;
    wire hit_state = adr_hi_zero && adr == ssp_pkg::SSP_ADR_STATE;
    wire hit_pins = adr_hi_zero && adr == ssp_pkg::SSP_ADR_PINS;
    wire [7:0] wdat = wb_dat_i[7:0];

    wire busy = (phase_r != ssp_pkg::SSP_PH_IDLE) || slv_act_r || (samp_r != 2'h0);
    wire buf_wr = wr && hit_buf;
    wire buf_rd = rd && hit_buf;
    wire write_collision_flag_set = buf_wr && busy;
    wire load = buf_wr && !busy && (is_master || is_slave);
    wire m_start = is_master && !busy && (load || sck_is_in);
    // Master fills bit 0 two cycles after its trailing edge, once the synced pin shows it
    wire m_fill = is_master && samp_r[1];
    wire [7:0] rx_byte = m_fill ? {shreg_r[7:1], sdi_sync_r} :
                         {shreg_r[6:0], sdi_sync_r};
    wire ov_set = done && is_slave && bf_r;

    wire sck_edge = sck_sync_r != sck_prev_r;
    wire s_lead = slave_on && sck_edge && (sck_sync_r != clock_polarity_bit);
    wire s_trail = slave_on && sck_edge && (sck_sync_r == clock_polarity_bit);

    logic tick;
    wire m_trail = is_master && tick && (phase_r == ssp_pkg::SSP_PH_TRAIL);

    ssp_bitclk #(
        .CNT_W(5)
    ) u_bitclk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(is_master && phase_r != ssp_pkg::SSP_PH_IDLE && !sleep_i),
        .rate_i(mode[1:0]),
        .period_timer_two_tick_i(period_timer_two_tick_i),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine

    always_comb begin
        phase_nxt = phase_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        sck_nxt = sck_r;
        sdo_nxt = sdo_r;
        slv_act_nxt = slv_act_r;
        done = 1'b0;
        if (!en) begin
            phase_nxt = ssp_pkg::SSP_PH_IDLE;
            cnt_nxt = 3'h0;
            slv_act_nxt = 1'b0;
            sck_nxt = clock_polarity_bit;
        end else if (is_master) begin
            if (m_fill) begin
                shreg_nxt[0] = sdi_sync_r;
                done = (phase_r == ssp_pkg::SSP_PH_IDLE);
            end
            if (phase_r == ssp_pkg::SSP_PH_IDLE) begin
                sck_nxt = clock_polarity_bit;
                if (m_start) begin
                    phase_nxt = ssp_pkg::SSP_PH_LEAD;
                    cnt_nxt = 3'h0;
                end
                if (load) begin
                    shreg_nxt = wdat;
                end
            end else if (tick) begin
                unique case (phase_r)
                    ssp_pkg::SSP_PH_LEAD: begin
                        sck_nxt = !clock_polarity_bit;
                        sdo_nxt = shreg_r[7];
                        phase_nxt = ssp_pkg::SSP_PH_TRAIL;
                    end
                    ssp_pkg::SSP_PH_TRAIL: begin
                        sck_nxt = clock_polarity_bit;
                        shreg_nxt = {shreg_nxt[6:0], 1'b0};
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == 3'(ssp_pkg::SSP_FRAME_BITS - 1)) begin
                            phase_nxt = ssp_pkg::SSP_PH_IDLE;
                        end else begin
                            phase_nxt = ssp_pkg::SSP_PH_LEAD;
                        end
                    end
                    default: begin
                        phase_nxt = ssp_pkg::SSP_PH_IDLE;
                    end
                endcase
            end
        end else if (is_slave) begin
            phase_nxt = ssp_pkg::SSP_PH_IDLE;
            sck_nxt = clock_polarity_bit;
            if (load) begin
                shreg_nxt = wdat;
                cnt_nxt = 3'h0;
            end
            if (s_lead) begin
                sdo_nxt = shreg_r[7];
                slv_act_nxt = 1'b1;
            end else if (s_trail) begin
                shreg_nxt = rx_byte;
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == 3'(ssp_pkg::SSP_FRAME_BITS - 1)) begin
                    done = 1'b1;
                    slv_act_nxt = 1'b0;
                end
            end
        end else begin
            phase_nxt = ssp_pkg::SSP_PH_IDLE;
            slv_act_nxt = 1'b0;
            sck_nxt = clock_polarity_bit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= ssp_pkg::SSP_PH_IDLE;
            cnt_r <= 3'h0;
            shreg_r <= 8'h00;
            sck_r <= 1'b0;
            sdo_r <= 1'b0;
            slv_act_r <= 1'b0;
            samp_r <= 2'h0;
        end else begin
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            sck_r <= sck_nxt;
            sdo_r <= sdo_nxt;
            slv_act_r <= slv_act_nxt;
            samp_r <= {samp_r[0], m_trail};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_meta_r <= 1'b0;
            sck_sync_r <= 1'b0;
            sck_prev_r <= 1'b0;
            sdi_meta_r <= 1'b0;
            sdi_sync_r <= 1'b0;
            sel_meta_r <= 1'b1;
            sel_sync_r <= 1'b1;
        end else begin
            sck_meta_r <= sck_i;
            sck_sync_r <= sck_meta_r;
            sck_prev_r <= sck_sync_r;
            sdi_meta_r <= sdi_i;
            sdi_sync_r <= sdi_meta_r;
            sel_meta_r <= sel_n_i;
            sel_sync_r <= sel_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers and flags

    wire write_collision_flag_nxt = write_collision_flag_set || ((wr && hit_ctrl) ? wdat[ssp_pkg::SSP_CTL_WRITE_COLLISION_FLAG] :
                                 ctrl_r[ssp_pkg::SSP_CTL_WRITE_COLLISION_FLAG]);
    wire ov_nxt = ov_set || ((wr && hit_ctrl) ? wdat[ssp_pkg::SSP_CTL_OV] :
                             ctrl_r[ssp_pkg::SSP_CTL_OV]);
    wire [5:0] cfg_nxt = (wr && hit_ctrl) ? wdat[5:0] : ctrl_r[5:0];
    wire bf_nxt = (done && !ov_set) || (bf_r && !buf_rd);
    wire pif_clr = wr && hit_state && wdat[ssp_pkg::SSP_ST_PIF];
    wire pif_nxt = done || (pif_r && !pif_clr);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= ssp_pkg::SSP_CTRL_RST;
            pins_r <= ssp_pkg::SSP_PINS_RST;
            bf_r <= 1'b0;
            pif_r <= 1'b0;
        end else begin
            ctrl_r <= {write_collision_flag_nxt, ov_nxt, cfg_nxt};
            pins_r <= (wr && hit_pins) ? wdat : pins_r;
            bf_r <= bf_nxt;
            pif_r <= pif_nxt;
        end
    end

    // Overflowed bytes never reach the buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_r <= ssp_pkg::SSP_BUF_RST;
        end else if (done && !ov_set) begin
            buf_r <= rx_byte;
        end else if (load) begin
            buf_r <= wdat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer and pins

    wire [7:0] state_val = {2'b00, sel_sync_r, sdi_sync_r, sck_sync_r, busy, pif_r, bf_r};
    wire [7:0] rd_val = hit_ctrl ? ctrl_r :
                        hit_buf ? buf_r :
                        hit_state ? state_val :
                        hit_pins ? pins_r : 8'h00;

    // Pins fall back to plain I/O set by the pin control register while the port is off
    wire sck_pin_nxt = (en && is_master) ? sck_nxt : pins_r[ssp_pkg::SSP_PIN_SCK_VAL];
    wire sck_oe_nxt = !sck_is_in && (!en || is_master);
    wire sdo_pin_nxt = en ? sdo_nxt : pins_r[ssp_pkg::SSP_PIN_SDO_VAL];
    wire sdo_oe_nxt = !sdo_is_in && (!en || is_master || slave_on);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            sck_o <= 1'b0;
            sck_oe_o <= 1'b0;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= rd ? {24'h00_0000, rd_val} : 32'h0000_0000;
            sck_o <= sck_pin_nxt;
            sck_oe_o <= sck_oe_nxt;
            sdo_o <= sdo_pin_nxt;
            sdo_oe_o <= sdo_oe_nxt;
            wake_o <= done && is_slave && sleep_i;
        end
    end

endmodule

/* File: testbench/ssp_spi_assertions.sv */
`timescale 1ns/10ps
module ssp_spi_assertions #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sck_o,
    input wire logic sdo_oe_o,
    input wire logic sel_n_i,
    input wire logic sleep_i,
    input wire logic wake_o
);
    logic [7:0] ctrl_r;
    logic take;
    logic wr;
    logic master;
    logic clock_polarity_bit;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && wb_sel_i[0];
    assign master = ctrl_r[5] && (ctrl_r[3:0] < 4'h3);
    assign clock_polarity_bit = ctrl_r[4];
    // Shadow of the control byte as written over the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 8'h00;
        end else if (wr && wb_adr_i == ADR_W'(ssp_pkg::SSP_ADR_CTRL)) begin
            ctrl_r <= wb_dat_i[7:0];
        end
    end
    ////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_dat_quiet; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
    property p_start;
        wr && wb_adr_i == ADR_W'(ssp_pkg::SSP_ADR_BUF) && master && sck_o == clock_polarity_bit
            |-> ##[1:40] sck_o != clock_polarity_bit;
    endproperty
    a_start: assert property (p_start) else $error("buffer write did not start clock");
    property p_idle; $rose(ctrl_r[5]) && ctrl_r[3:0] < 4'h4 |-> ##2 sck_o == clock_polarity_bit; endproperty
    a_idle: assert property (p_idle) else $error("clock not at idle level");
    property p_gate; (ctrl_r[5] && ctrl_r[3:0] == 4'h4 && sel_n_i) [*6] |-> !sdo_oe_o; endproperty
    a_gate: assert property (p_gate) else $error("data out driven while deselected");
    property p_wake_pulse; wake_o |=> !wake_o; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
    property p_wake_sleep; wake_o |-> $past(sleep_i); endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
endmodule

bind ssp_spi ssp_spi_assertions #(.ADR_W(ADR_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_o(sck_o), .sdo_oe_o(sdo_oe_o),
    .sel_n_i(sel_n_i), .sleep_i(sleep_i), .wake_o(wake_o));

/* File: testbench/ssp_peer.sv */
`timescale 1ns/10ps
module ssp_peer #(
    parameter int HALF = 10
) (
    input wire logic clk_i,
    input wire logic ckp_i,
    input wire logic dut_master_i,
    input wire logic sck_i,
    input wire logic miso_i,
    output logic sck_o,
    output logic dout_o
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic [7:0] mrx = 8'h00;
    logic sdout = 1'b0;
    logic mdout = 1'b0;
    initial sck_o = 1'b0;
    assign dout_o = dut_master_i ? sdout : mdout;
    // Slave role: shift out on the leading edge, capture on the trailing one
    always @(sck_i) begin
        if (dut_master_i && sck_i !== ckp_i) begin
            sdout <= tx[7];
            tx <= {tx[6:0], 1'b0};
        end else if (dut_master_i) begin
            rx <= {rx[6:0], miso_i};
        end
    end
    task automatic load(input logic [7:0] b);
        tx = b;
    endtask
    // Master role: clock idles at the polarity level between frames
    task automatic xfer(input logic [7:0] b, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk_i);
            sck_o <= ~ckp_i;
            mdout <= b[7-i];
            repeat (HALF) @(posedge clk_i);
            sck_o <= ckp_i;
            mrx <= {mrx[6:0], miso_i};
            repeat (HALF) @(posedge clk_i);
        end
        mdout <= ~mdout;
    endtask
endmodule

/* File: testbench/ssp_spi_bench.sv */
`timescale 1ns/10ps
module ssp_spi_bench;
    typedef struct {logic [7:0] ctrl; logic [7:0] tx; logic [7:0] prx; int half;} ssp_row_type;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic sel_n_i = 1'b1;
    logic sleep_i = 1'b0;
    logic period_timer_two_tick_i = 1'b0;
    logic clock_polarity_bit = 1'b0;
    logic sdo_last = 1'b0;
    logic woke = 1'b0;
    logic sck_prev = 1'b0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, wake_o, psck, pdout;
    int tcnt = 0, cnt = 0, half_seen = 0, fail_count = 0, n_checks = 0;
    ssp_row_type rows [4] = '{'{8'h20, 8'hA5, 8'h3C, 2}, '{8'h31, 8'h81, 8'h7E, 8},
        '{8'h22, 8'h4B, 8'hD2, 32}, '{8'h33, 8'h19, 8'hE6, 6}};
    // A released data line shows the inverse of its last value; a released clock line shows the peer's clock
    wire sck_w = sck_oe_o ? sck_o : psck;
    wire sdo_w = sdo_oe_o ? sdo_o : ~sdo_last;
    ssp_spi #(.ADR_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(pdout), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .sel_n_i(sel_n_i), .period_timer_two_tick_i(period_timer_two_tick_i), .sleep_i(sleep_i), .wake_o(wake_o));
    ssp_peer #(.HALF(10)) peer (.clk_i(clk_i), .ckp_i(clock_polarity_bit), .dut_master_i(sck_oe_o),
        .sck_i(sck_w), .miso_i(sdo_w), .sck_o(psck), .dout_o(pdout));
    initial forever #20 clk_i = ~clk_i;
    // Timer tick every 6 clocks; measure clock half periods
    always @(posedge clk_i) begin
        tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
        period_timer_two_tick_i <= (tcnt == 5);
        cnt <= (sck_o != sck_prev) ? 1 : cnt + 1;
        if (sck_o != sck_prev) half_seen <= cnt;
        sck_prev <= sck_o;
        if (sdo_oe_o) sdo_last <= sdo_o;
        if (wake_o === 1'b1) woke <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cfg(input logic [7:0] c);
        clock_polarity_bit <= c[4];
        bus(1, ssp_pkg::SSP_ADR_CTRL, 8'h00);
        bus(1, ssp_pkg::SSP_ADR_CTRL, c);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(0, ssp_pkg::SSP_ADR_STATE, 8'h00);
            n++;
        end while (q[ssp_pkg::SSP_ST_BUSY] !== 1'b0 && n < 500);
        if (n == 500) fail_count++;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(sck_oe_o | sdo_oe_o), 32'h0);
        bus(0, ssp_pkg::SSP_ADR_CTRL, 8'h00);
        check(q, 32'(ssp_pkg::SSP_CTRL_RST));
        bus(0, ssp_pkg::SSP_ADR_PINS, 8'h00);
        check(q, 32'(ssp_pkg::SSP_PINS_RST));
        bus(1, 8'h10, 8'hFF);
        bus(0, 8'h10, 8'h00);
        check(q, 32'h0);
        bus(1, ssp_pkg::SSP_ADR_PINS, 8'h00);
        foreach (rows[i]) begin
            cfg(rows[i].ctrl);
            check(32'(sck_o), 32'(rows[i].ctrl[4]));
            peer.load(rows[i].prx);
            bus(1, ssp_pkg::SSP_ADR_BUF, rows[i].tx);
            wait_idle();
            check(half_seen, rows[i].half);
            check(32'(peer.rx), 32'(rows[i].tx));
            bus(0, ssp_pkg::SSP_ADR_STATE, 8'h00);
            check(q & 32'h3, 32'h3);
            bus(0, ssp_pkg::SSP_ADR_BUF, 8'h00);
            check(q, 32'(rows[i].prx));
            bus(0, ssp_pkg::SSP_ADR_STATE, 8'h00);
            check(q & 32'h1, 32'h0);
            bus(0, ssp_pkg::SSP_ADR_CTRL, 8'h00);
            check(q & 32'hC0, 32'h0);
            bus(1, ssp_pkg::SSP_ADR_STATE, 8'h02);
        end
        cfg(8'h21);
        peer.load(8'h00);
        bus(1, ssp_pkg::SSP_ADR_BUF, 8'h11);
        bus(1, ssp_pkg::SSP_ADR_BUF, 8'h22);
        wait_idle();
        check(32'(peer.rx), 32'h11);
        bus(0, ssp_pkg::SSP_ADR_CTRL, 8'h00);
        check(q, 32'hA1);
        bus(0, ssp_pkg::SSP_ADR_BUF, 8'h00);
        bus(1, ssp_pkg::SSP_ADR_STATE, 8'h02);
        bus(1, ssp_pkg::SSP_ADR_PINS, 8'h01);
        cfg(8'h25);
        bus(1, ssp_pkg::SSP_ADR_BUF, 8'hC3);
        sleep_i <= 1'b1;
        peer.xfer(8'h96, 8);
        repeat (4) @(posedge clk_i);
        sleep_i <= 1'b0;
        check(32'(woke), 32'h1);
        check(32'(peer.mrx), 32'hC3);
        bus(0, ssp_pkg::SSP_ADR_STATE, 8'h00);
        check(q & 32'h3, 32'h3);
        peer.xfer(8'h69, 8);
        repeat (4) @(posedge clk_i);
        bus(0, ssp_pkg::SSP_ADR_CTRL, 8'h00);
        check(q, 32'h65);
        bus(0, ssp_pkg::SSP_ADR_BUF, 8'h00);
        check(q, 32'h96);
        bus(0, ssp_pkg::SSP_ADR_CTRL, 8'h00);
        check(q, 32'h65);
        sel_n_i <= 1'b0;
        cfg(8'h24);
        bus(1, ssp_pkg::SSP_ADR_BUF, 8'hF0);
        peer.xfer(8'h5A, 4);
        sel_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check(32'(sdo_oe_o), 32'h0);
        sel_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        peer.xfer(8'hA0, 4);
        repeat (4) @(posedge clk_i);
        check(32'(peer.mrx), 32'hF0);
        bus(0, ssp_pkg::SSP_ADR_BUF, 8'h00);
        check(q, 32'h5A);
        // Clock pin as input: the master keeps taking in the peer's idle data level
        cfg(8'h20);
        repeat (40) @(posedge clk_i);
        bus(0, ssp_pkg::SSP_ADR_BUF, 8'h00);
        check(q, 32'hFF);
        repeat (80) @(posedge clk_i);
        bus(0, ssp_pkg::SSP_ADR_CTRL, 8'h00);
        check(q, 32'h20);
        end_of_test();
    end
endmodule
